// ### hdl/ctp_regs.svh
// register map, reset values and timing constants of the trigger/timebase block
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH
`define CTP_ADR_CTRL 8'h00
`define CTP_ADR_PER0 8'h04
`define CTP_ADR_WID0 8'h08
`define CTP_ADR_PER1 8'h0C
`define CTP_ADR_WID1 8'h10
`define CTP_ADR_TIME 8'h14
`define CTP_ADR_STAMP 8'h18
`define CTP_ADR_CAM 8'h1C
`define CTP_ADR_STAT 8'h20
`define CTP_CTRL_W 3
`define CTP_CTRL_TRIG0 0
`define CTP_CTRL_TRIG1 1
`define CTP_CTRL_PPS 2
`define CTP_RST_CTRL 3'h0
`define CTP_RST_PER 32'h0000_9C40
`define CTP_RST_WID 32'h0000_0FA0
`define CTP_STAT_PEND 0
`define CTP_NTRIG 2
`define CTP_US_NS 1000
`define CTP_CLK_NS 25
`endif

// ### hdl/ctp_pkg.sv
// shared types of the trigger/timebase block
package ctp_pkg;
  typedef logic [31:0] ctp_word_t;
  typedef logic [7:0] ctp_adr_t;
  typedef logic [3:0] ctp_sel_t;
endpackage

// ### hdl/ctp_sync2.sv
// two-flop synchroniser for pins from outside the ref_clk domain
`timescale 1ns/1ps
module ctp_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### hdl/ctp_trig_gen.sv
// one periodic trigger pulse generator, width and period in ref_clk cycles
`timescale 1ns/1ps
module ctp_trig_gen (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic en,
  input wire ctp_pkg::ctp_word_t period,
  input wire ctp_pkg::ctp_word_t width,
  output logic trig_q,
  output logic rise_q
);
  import ctp_pkg::*;
  ctp_word_t cnt_q, cnt_d, wid;
  logic trig_d, rise_d;

  // phase counter; parked at the last phase so enable starts a pulse at once
  always_comb begin
    wid = (width >= period) ? period - 32'h1 : width; // RULE11
    cnt_d = period - 32'h1;
    trig_d = 1'b0;
    if (en && period != '0) begin
      cnt_d = (cnt_q >= period - 32'h1) ? '0 : cnt_q + 32'h1; // RULE11
      trig_d = cnt_d < wid; // RULE3
    end
    rise_d = trig_d & ~trig_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= '0;
      trig_q <= 1'b0; // RULE2
      rise_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      trig_q <= trig_d; // RULE2
      rise_q <= rise_d;
    end
  end

  // checking helpers: high length, rise spacing, config stability
  ctp_word_t hi_q, gap_q, per_h_q, wid_h_q;
  logic ok_q, chg;
  assign chg = (period != per_h_q) || (width != wid_h_q);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hi_q <= '0;
      gap_q <= '0;
      ok_q <= 1'b0;
      per_h_q <= '0;
      wid_h_q <= '0;
    end else begin
      hi_q <= trig_q ? hi_q + 32'h1 : '0;
      gap_q <= rise_q ? 32'h1 : gap_q + 32'h1;
      ok_q <= (!en || chg) ? 1'b0 : (rise_q ? 1'b1 : ok_q);
      per_h_q <= period;
      wid_h_q <= width;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_trig_idle_low: assert property (!en ##1 !en |-> !trig_q) // RULE2
    else $error("trigger high while disabled");
  a_trig_high_len: assert property ($fell(trig_q) && ok_q && !chg |-> hi_q == $past(wid)) // RULE3
    else $error("trigger pulse width wrong");
  a_trig_period: assert property (rise_q && ok_q && !chg && en |-> gap_q == period) // RULE11
    else $error("trigger period wrong");
endmodule

// ### hdl/ctp_top.sv
// camera trigger generator and microsecond timebase with pps clear, wishbone slave
`timescale 1ns/1ps
`include "ctp_regs.svh"
//Contract
// RULE1 - The block drives up to two independent camera trigger outputs.
// RULE2 - A trigger output is high while active and low otherwise.
// RULE3 - Pulse width and repetition frequency come from software settings.
// RULE4 - Cameras should start exposure on the rising edge of the trigger.
// RULE5 - A newly attached camera is put in external trigger mode on the lowest free line.
// RULE6 - With pps sync enabled, each rising pps edge clears the time counter to 0.
// RULE7 - The pps source gives one rising edge per second.
// RULE8 - The time counter counts microseconds and stamps each output image set.
// RULE9 - Without sync the counter starts at zero after reset and runs freely.
// RULE10 - A clear between trigger and output makes that image's stamp negative.
// RULE11 - Pulses repeat at the set period and the width is kept below it.
module ctp_top #(
  parameter int NCAM = 2
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire ctp_pkg::ctp_adr_t wb_adr,
  input wire ctp_pkg::ctp_sel_t wb_sel,
  input wire ctp_pkg::ctp_word_t wb_dat_w,
  output ctp_pkg::ctp_word_t wb_dat_r,
  output logic wb_ack,
  input wire logic pps_pin,
  input wire logic [NCAM-1:0] cam_attach,
  input wire logic img_done,
  output logic [`CTP_NTRIG-1:0] trig_out,
  output logic [NCAM-1:0] cam_ext_trig,
  output logic [NCAM-1:0] cam_line,
  output ctp_pkg::ctp_word_t time_us,
  output ctp_pkg::ctp_word_t img_stamp,
  output logic img_stamp_vld
);
  import ctp_pkg::*;

  localparam int US_CYC = `CTP_US_NS / `CTP_CLK_NS;
  localparam int PW = $clog2(US_CYC);
  localparam logic [PW-1:0] PRE_LAST = PW'(US_CYC - 1);

  // byte-lane merge for wishbone writes
  function automatic ctp_word_t wmerge(ctp_word_t old, ctp_word_t nw, ctp_sel_t sel);
    ctp_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ---- external pins through synchronisers
  logic pps_s, pps_prev_q, pps_rise, clr;
  logic [NCAM-1:0] cam_s;

  ctp_sync2 #(.W(1)) u_pps_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d(pps_pin),
    .q(pps_s)
  );

  ctp_sync2 #(.W(NCAM)) u_cam_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d(cam_attach),
    .q(cam_s)
  );

  // edge seen on the synchronised level only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pps_prev_q <= 1'b0;
    end else begin
      pps_prev_q <= pps_s;
    end
  end

  assign pps_rise = pps_s & ~pps_prev_q;

  // ---- register file and bus slave
  logic ack_q, ack_d, acc, wr;
  ctp_word_t rdat_q, rdat_d, tmp;
  logic [`CTP_CTRL_W-1:0] ctrl_q, ctrl_d;
  ctp_word_t per_q [`CTP_NTRIG];
  ctp_word_t per_d [`CTP_NTRIG];
  ctp_word_t wid_q [`CTP_NTRIG];
  ctp_word_t wid_d [`CTP_NTRIG];
  ctp_word_t time_q, time_d, stamp_q, stamp_d;
  logic [NCAM-1:0] cam_on_q, cam_line_q;
  logic pend_q;

  // single-wait-state slave: ack one cycle after the strobe, write at the ack edge
  always_comb begin
    acc = wb_cyc & wb_stb;
    ack_d = acc & ~ack_q;
    wr = acc & wb_we & ack_q;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    per_d = per_q;
    wid_d = wid_q;
    tmp = '0;
    if (ack_d) begin
      case (wb_adr)
        `CTP_ADR_CTRL: rdat_d = 32'(ctrl_q);
        `CTP_ADR_PER0: rdat_d = per_q[0];
        `CTP_ADR_WID0: rdat_d = wid_q[0];
        `CTP_ADR_PER1: rdat_d = per_q[1];
        `CTP_ADR_WID1: rdat_d = wid_q[1];
        `CTP_ADR_TIME: rdat_d = time_q;
        `CTP_ADR_STAMP: rdat_d = stamp_q;
        `CTP_ADR_CAM: rdat_d = 32'({cam_line_q, cam_on_q});
        `CTP_ADR_STAT: rdat_d = 32'(pend_q);
        default: rdat_d = '0; // unmapped reads zero, still acked
      endcase
    end
    if (wr) begin
      case (wb_adr)
        `CTP_ADR_CTRL: begin
          tmp = wmerge(32'(ctrl_q), wb_dat_w, wb_sel);
          ctrl_d = tmp[`CTP_CTRL_W-1:0];
        end
        `CTP_ADR_PER0: per_d[0] = wmerge(per_q[0], wb_dat_w, wb_sel); // RULE3
        `CTP_ADR_WID0: wid_d[0] = wmerge(wid_q[0], wb_dat_w, wb_sel); // RULE3
        `CTP_ADR_PER1: per_d[1] = wmerge(per_q[1], wb_dat_w, wb_sel); // RULE3
        `CTP_ADR_WID1: wid_d[1] = wmerge(wid_q[1], wb_dat_w, wb_sel); // RULE3
        default: tmp = '0; // read-only and unmapped writes dropped
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= `CTP_RST_CTRL;
      for (int t = 0; t < `CTP_NTRIG; t++) begin
        per_q[t] <= `CTP_RST_PER;
        wid_q[t] <= `CTP_RST_WID;
      end
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      per_q <= per_d;
      wid_q <= wid_d;
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = rdat_q;

  // ---- trigger generators, one per line
  logic [`CTP_NTRIG-1:0] trig_rise;

  for (genvar g = 0; g < `CTP_NTRIG; g++) begin : g_trig
    ctp_trig_gen u_gen (
      .ref_clk(ref_clk),
      .srst(srst),
      .en(ctrl_q[g]), // RULE1
      .period(per_q[g]),
      .width(wid_q[g]),
      .trig_q(trig_out[g]), // RULE2
      .rise_q(trig_rise[g])
    );
  end

  // ---- microsecond timebase
  logic [PW-1:0] pre_q, pre_d;

  // prescaler and counter restart together so the first microsecond is whole
  always_comb begin
    clr = pps_rise & ctrl_q[`CTP_CTRL_PPS];
    pre_d = pre_q + 1'b1;
    time_d = time_q;
    if (clr) begin
      pre_d = '0; // RULE6
      time_d = '0; // RULE6
    end else if (pre_q == PRE_LAST) begin
      pre_d = '0;
      time_d = time_q + 32'h1; // RULE8 RULE9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pre_q <= '0;
      time_q <= '0; // RULE9
    end else begin
      pre_q <= pre_d;
      time_q <= time_d;
    end
  end

  assign time_us = time_q;

  // ---- image timestamp: latched at trigger, rebased on clear, issued on done
  logic pend_d, ivld_q, ivld_d;
  ctp_word_t istamp_q, istamp_d;
  logic any_rise;

  // a clear shifts a pending stamp by the elapsed time, giving a negative value
  always_comb begin
    any_rise = |trig_rise;
    stamp_d = stamp_q;
    pend_d = pend_q;
    istamp_d = istamp_q;
    ivld_d = 1'b0;
    if (clr && pend_q) begin
      stamp_d = stamp_q - time_q; // RULE10
    end
    if (any_rise) begin
      stamp_d = clr ? '0 : time_q; // RULE8
      pend_d = 1'b1;
    end
    if (img_done) begin
      istamp_d = stamp_q; // RULE8
      ivld_d = 1'b1;
      pend_d = any_rise; // a new trigger in the same cycle stays pending
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stamp_q <= '0;
      pend_q <= 1'b0;
      istamp_q <= '0;
      ivld_q <= 1'b0;
    end else begin
      stamp_q <= stamp_d;
      pend_q <= pend_d;
      istamp_q <= istamp_d;
      ivld_q <= ivld_d;
    end
  end

  assign img_stamp = istamp_q;
  assign img_stamp_vld = ivld_q;

  // ---- camera attach: external trigger mode on the lowest free line
  logic [NCAM-1:0] cam_on_d, cam_line_d;
  logic [`CTP_NTRIG-1:0] used;

  // level based so a camera left without a line retries once one frees up
  always_comb begin
    used = '0;
    cam_on_d = cam_on_q & cam_s;
    cam_line_d = cam_line_q;
    for (int i = 0; i < NCAM; i++) begin
      if (cam_on_d[i]) begin
        used[cam_line_q[i]] = 1'b1;
      end
    end
    for (int i = 0; i < NCAM; i++) begin
      if (cam_s[i] && !cam_on_q[i]) begin
        if (!used[0]) begin
          cam_on_d[i] = 1'b1; // RULE5
          cam_line_d[i] = 1'b0; // RULE5
          used[0] = 1'b1;
        end else if (!used[1]) begin
          cam_on_d[i] = 1'b1;
          cam_line_d[i] = 1'b1; // RULE5
          used[1] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cam_on_q <= '0;
      cam_line_q <= '0;
    end else begin
      cam_on_q <= cam_on_d;
      cam_line_q <= cam_line_d;
    end
  end

  assign cam_ext_trig = cam_on_q;
  assign cam_line = cam_line_q;

  // ---- checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_trig_line_en: assert property ($rose(trig_out[1]) |-> $past(ctrl_q[`CTP_CTRL_TRIG1])) // RULE1
    else $error("trigger line 1 rose while disabled");
  a_cam_first_line: assert property (cam_s[0] && !cam_on_q[0] && cam_on_q == '0
      |=> cam_on_q[0] && !cam_line_q[0]) // RULE5
    else $error("camera not given line 0");
  a_cam_distinct: assert property (cam_on_q[0] && cam_on_q[1]
      |-> cam_line_q[0] != cam_line_q[1]) // RULE5
    else $error("two cameras share a line");
  a_pps_clear: assert property (pps_rise && ctrl_q[`CTP_CTRL_PPS]
      |=> time_q == '0 && pre_q == '0) // RULE6
    else $error("pps edge did not clear time");
  a_pps_ignored: assert property (pps_rise && !ctrl_q[`CTP_CTRL_PPS] && pre_q != PRE_LAST
      |=> $stable(time_q)) // RULE9
    else $error("time moved on ignored pps");
  // a pps clear right after a tick may legally move the count again
  a_us_tick: assert property (pre_q == PRE_LAST && !clr
      |=> time_q == $past(time_q) + 32'h1 ##1 ($stable(time_q) || $past(clr))) // RULE8
    else $error("microsecond tick wrong");
  a_time_zero: assert property ($past(srst) |-> time_q == '0) // RULE9
    else $error("time not zero after reset");
  a_stamp_neg: assert property (clr && pend_q && !any_rise
      |=> stamp_q == $past(stamp_q) - $past(time_q)) // RULE10
    else $error("pending stamp not rebased");
  a_img_stamp: assert property (img_done |=> img_stamp_vld && img_stamp == $past(stamp_q)) // RULE8
    else $error("image stamp not issued");
  a_ack_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("ack held two cycles");

  c_pps_clear: cover property (clr && pend_q);
  c_neg_stamp: cover property (img_stamp_vld && img_stamp[31]);
  c_two_cams: cover property (cam_on_q[0] && cam_on_q[1]);
  c_both_trig: cover property (trig_out[0] && trig_out[1]);
endmodule

// ### sim/ctp_far_model.sv
// far-side model: a pps source and two cameras watching the trigger lines
`timescale 1ns/1ps
module ctp_far_model (
  input wire logic ref_clk,
  input wire logic [1:0] trig_out,
  input wire logic pps_fire,
  input wire logic [1:0] plug,
  output logic pps_pin,
  output logic [1:0] cam_attach,
  output int exposures
);
  logic fire_q;
  logic [1:0] trig_q;
  int hi_cnt;
  initial begin
    pps_pin = 1'b0;
    fire_q = 1'b0;
    trig_q = 2'h0;
    hi_cnt = 0;
    exposures = 0;
  end
  // one rising edge per request; held high a few cycles like a real pulse
  always @(posedge ref_clk) begin
    fire_q <= pps_fire;
    if (pps_fire != fire_q) begin
      pps_pin <= 1'b1;
      hi_cnt <= 4;
    end else if (hi_cnt > 0) begin
      hi_cnt <= hi_cnt - 1;
    end else begin
      pps_pin <= 1'b0;
    end
  end
  // exposure only on a low-to-high edge, so a stuck-high line counts once
  always @(posedge ref_clk) begin
    trig_q <= trig_out;
    if ((trig_out & ~trig_q) != 2'h0) begin
      exposures <= exposures + 1;
    end
  end
  // presence level of each camera slot
  assign cam_attach = plug;
endmodule

// ### sim/camera_trigger_and_pps_timebase_tb_top.sv
// self-checking bench: bus tasks, trigger timing, pps clear, stamps, camera lines
`timescale 1ns/1ps
`include "ctp_regs.svh"
module camera_trigger_and_pps_timebase_tb_top;
  import ctp_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  ctp_adr_t wb_adr = 8'h00;
  ctp_sel_t wb_sel = 4'h0;
  ctp_word_t wb_dat_w = 32'h0, wb_dat_r, time_us, img_stamp, r, t0, tp;
  logic wb_ack, img_done = 1'b0, img_stamp_vld, pps_pin, pps_fire = 1'b0;
  logic [1:0] trig_out, cam_ext_trig, cam_line, cam_attach, plug = 2'h0;
  int num_errors = 0, compares = 0, exposures, w, p;
  ctp_top #(.NCAM(2)) uut (.ref_clk(ref_clk), .srst(srst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .pps_pin(pps_pin), .cam_attach(cam_attach),
    .img_done(img_done), .trig_out(trig_out), .cam_ext_trig(cam_ext_trig),
    .cam_line(cam_line), .time_us(time_us), .img_stamp(img_stamp),
    .img_stamp_vld(img_stamp_vld));
  ctp_far_model far (.ref_clk(ref_clk), .trig_out(trig_out), .pps_fire(pps_fire),
    .plug(plug), .pps_pin(pps_pin), .cam_attach(cam_attach), .exposures(exposures));
  // 40 MHz
  always #12.5 ref_clk = ~ref_clk;
  task automatic check(input string name, input ctp_word_t seen, input ctp_word_t exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one classic cycle; values sampled at an edge are the pre-edge ones
  task automatic wb(input logic we, input ctp_adr_t a, input ctp_word_t d,
    input ctp_sel_t s = 4'hF);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    check("wb_ack", ctp_word_t'(n < 50), 32'h1);
  endtask
  // width and period of line g in cycles, bounded waits
  task automatic meas(input int g);
    int n;
    n = 0;
    while (trig_out[g] !== 1'b0 && n < 3000) begin @(posedge ref_clk); n++; end
    while (trig_out[g] !== 1'b1 && n < 3000) begin @(posedge ref_clk); n++; end
    w = 0;
    while (trig_out[g] === 1'b1 && w < 3000) begin @(posedge ref_clk); w++; end
    p = w;
    while (trig_out[g] !== 1'b1 && p < 3000) begin @(posedge ref_clk); p++; end
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    check("trig_rst", ctp_word_t'(trig_out), 32'h0);
    check("time_rst", time_us, 32'h0);
    wb(1'b0, `CTP_ADR_CTRL, 32'h0);
    check("ctrl_rst", r, 32'h0);
    wb(1'b0, `CTP_ADR_PER0, 32'h0);
    check("per_rst", r, `CTP_RST_PER);
    wb(1'b0, `CTP_ADR_WID1, 32'h0);
    check("wid_rst", r, `CTP_RST_WID);
    // a single byte lane lands, the other lanes keep their reset value
    wb(1'b1, `CTP_ADR_WID1, 32'h1234_5678, 4'h4);
    wb(1'b0, `CTP_ADR_WID1, 32'h0);
    check("wid_lane", r, (`CTP_RST_WID & 32'hFF00_FFFF) | 32'h0034_0000);
    wb(1'b0, `CTP_ADR_TIME, 32'h0);
    check("time_reg", ctp_word_t'(time_us - r < 32'd2), 32'h1);
    wb(1'b0, 8'h24, 32'h0);
    check("unmapped", r, 32'h0);
    // microsecond step: 40 cycles per count
    t0 = time_us;
    while (time_us === t0) @(posedge ref_clk);
    t0 = time_us;
    repeat (39) @(posedge ref_clk);
    check("time_hold", time_us, t0);
    @(posedge ref_clk);
    check("time_step", time_us, t0 + 32'h1);
    // line 0 alone, then line 1 with width clamped below the period
    wb(1'b1, `CTP_ADR_PER0, 32'd10);
    wb(1'b1, `CTP_ADR_WID0, 32'd3);
    wb(1'b1, `CTP_ADR_CTRL, 32'h1);
    meas(0);
    check("wid0", ctp_word_t'(w), 32'd3);
    check("per0", ctp_word_t'(p), 32'd10);
    check("line1_idle", ctp_word_t'(trig_out[1]), 32'h0);
    wb(1'b1, `CTP_ADR_PER1, 32'd8);
    wb(1'b1, `CTP_ADR_WID1, 32'd8);
    wb(1'b1, `CTP_ADR_CTRL, 32'h2);
    meas(1);
    check("wid1_clamp", ctp_word_t'(w), 32'd7);
    check("per1", ctp_word_t'(p), 32'd8);
    check("line0_off", ctp_word_t'(trig_out[0]), 32'h0);
    wb(1'b1, `CTP_ADR_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    check("trig_off", ctp_word_t'(trig_out), 32'h0);
    check("exposed", ctp_word_t'(exposures > 2), 32'h1);
    // pps ignored while sync is off
    pps_fire <= ~pps_fire;
    repeat (10) @(posedge ref_clk);
    check("pps_off", ctp_word_t'(time_us == 32'h0), 32'h0);
    // sync on: pending stamp rebased to a negative difference
    wb(1'b1, `CTP_ADR_PER0, 32'd1000);
    wb(1'b1, `CTP_ADR_CTRL, 32'h5);
    while (trig_out[0] !== 1'b1) @(posedge ref_clk);
    wb(1'b0, `CTP_ADR_STAMP, 32'h0);
    t0 = r;
    check("stamp_now", ctp_word_t'(time_us - t0 < 32'd2), 32'h1);
    repeat (200) @(posedge ref_clk);
    tp = time_us;
    pps_fire <= ~pps_fire;
    repeat (8) @(posedge ref_clk);
    check("pps_clear", time_us, 32'h0);
    wb(1'b0, `CTP_ADR_STAT, 32'h0);
    check("pending", r, 32'h1);
    wb(1'b0, `CTP_ADR_STAMP, 32'h0);
    check("stamp_neg", ctp_word_t'(r + tp - t0 inside {32'h0, 32'hFFFF_FFFF}), 32'h1);
    @(posedge ref_clk);
    img_done <= 1'b1;
    @(posedge ref_clk);
    img_done <= 1'b0;
    @(posedge ref_clk);
    check("stamp_vld", ctp_word_t'(img_stamp_vld), 32'h1);
    check("img_stamp", img_stamp, r);
    wb(1'b1, `CTP_ADR_CTRL, 32'h0);
    // cameras take the lowest free line in order of arrival
    plug <= 2'b10;
    repeat (6) @(posedge ref_clk);
    check("cam1_ext", ctp_word_t'(cam_ext_trig), 32'h2);
    check("cam1_line", ctp_word_t'(cam_line[1]), 32'h0);
    plug <= 2'b11;
    repeat (6) @(posedge ref_clk);
    check("cam0_line", ctp_word_t'(cam_line[0]), 32'h1);
    wb(1'b0, `CTP_ADR_CAM, 32'h0);
    check("cam_reg", r, 32'h7);
    plug <= 2'b01;
    repeat (6) @(posedge ref_clk);
    check("cam1_gone", ctp_word_t'(cam_ext_trig), 32'h1);
    // all lines free again: a lone camera must get line 0
    plug <= 2'b00;
    repeat (6) @(posedge ref_clk);
    check("cams_gone", ctp_word_t'(cam_ext_trig), 32'h0);
    plug <= 2'b01;
    repeat (6) @(posedge ref_clk);
    check("cam0_first", ctp_word_t'({cam_line[0], cam_ext_trig[0]}), 32'h1);
    give_verdict();
  end
endmodule
